// File: inc/adc_spi_pkg.sv
// Purpose: shared constants and carriers for the converter's serial readout block
// Assumes: mclk at 20 MHz; serial pins asynchronous to mclk
// Notes: hold limit is counted in mclk cycles from the end of sampling
package adc_spi_pkg;

   // ****************************************************************
   // widths and timing
   // ****************************************************************
   localparam int RESULT_BITS = 12;
   localparam int CONFIG_BITS = 4;
   localparam int MCLK_PERIOD_NS = 50;
   localparam int HOLD_TIME_NS = 1200000;
   // longest time, so round down
   localparam int HOLD_CYCLES = HOLD_TIME_NS / MCLK_PERIOD_NS;
   localparam logic [11:0] TRIAL_FIRST = 12'h800;
   localparam logic [3:0] MSB_INDEX = 4'hb;
   localparam logic [3:0] CONFIG_LAST = 4'h3;

   // ****************************************************************
   // carriers
   // ****************************************************************
   typedef struct packed {
      logic csN;
      logic sclk;
      logic din;
   } spi_in_t;

   typedef struct packed {
      logic inputModeSelect;
      logic channelSelectBit2;
      logic channelSelectBit1;
      logic channelSelectBit0;
   } chan_config_t;

   typedef enum logic [2:0] {
      S_IDLE,
      S_CONFIG,
      S_SAMPLE,
      S_CONVERT,
      S_LSBFIRST,
      S_ZEROS
   } link_state_t;

endpackage

// File: verilog/pin_sync.sv
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level
// Notes: only the second stage may be read by other logic
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 3
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pinAsync,
   output logic [WIDTH-1:0] pinSync
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         stage1_reg <= '1;
         pinSync <= '1;
      end
      else
      begin
         stage1_reg <= pinAsync;
         pinSync <= stage1_reg;
      end
   end
endmodule // pin_sync

// File: verilog/adc_spi_readout.sv
// Purpose: serial command and result readout of a 12-bit successive-approximation converter
// Assumes: serial clock far slower than mclk (at least 4 mclk per level)
// Notes: comparator input comes from the analog core on mclk
`timescale 1ns/1ns
// What this block does
// - chip select low, first high input bit starts
// - mode bit then three channel bits follow
// - null bit low, then 12 bits MSB first
// - extra clocks: LSB-first repeat, then zeros
// - clock may idle low or high
// - output changes only on falling edges
// - MSB appears on falling edge twelve
// - second byte: three hi-z clocks, null, four bits
// - third byte carries low eight result bits
// - one result bit resolved per clock
// - tolerate varying clock speed and duty
module adc_spi_readout
   import adc_spi_pkg::*;
#(
   parameter int HOLD_LIMIT = HOLD_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire spi_in_t pinsIn,
   input wire logic compareAbove,
   output logic dout,
   output logic doutOe,
   output chan_config_t chanConfig,
   output logic sampleHold,
   output logic [RESULT_BITS-1:0] trialCode,
   output logic [RESULT_BITS-1:0] result,
   output logic resultValid,
   output logic holdExpired
);

   // ****************************************************************
   // pin sampling and edge detection
   // ****************************************************************
   spi_in_t pinsSync;
   logic sclkPrev_reg;
   logic sclkRise;
   logic sclkFall;
   logic csLow;
   logic armed_reg;
   link_state_t state_reg;
   logic [3:0] bitCount_reg;
   logic sawRise_reg;
   logic [RESULT_BITS-1:0] resultBits_reg;
   logic [31:0] holdCount_reg;
   logic startEvt;
   logic nullEvt;
   logic convEvt;
   logic lsbEvt;
   logic zeroEvt;

   pin_sync #(.WIDTH(3)) syncPins (
      .mclk(mclk),
      .rst(rst),
      .pinAsync(pinsIn),
      .pinSync(pinsSync)
   );

   always_ff @(posedge mclk)
   begin
      // same as the synchroniser preset, so no false rising edge follows reset
      if (rst)
         sclkPrev_reg <= 1'b1;
      else
         sclkPrev_reg <= pinsSync.sclk;
   end

   // edges only, never levels: idle level of either mode is harmless
   assign sclkRise = pinsSync.sclk & ~sclkPrev_reg;
   assign sclkFall = ~pinsSync.sclk & sclkPrev_reg;
   assign csLow = ~pinsSync.csN;

   // armed once the synchronised select reads high, which the pin_sync reset preset already gives
   always_ff @(posedge mclk)
   begin
      if (rst)
         armed_reg <= 1'b0;
      else if (pinsSync.csN)
         armed_reg <= 1'b1;
   end

   assign startEvt = (state_reg == S_IDLE) && armed_reg && csLow && sclkRise
      && pinsSync.din;
   assign nullEvt = (state_reg == S_SAMPLE) && sawRise_reg && sclkFall && csLow;
   assign convEvt = (state_reg == S_CONVERT) && sclkFall && csLow;
   assign lsbEvt = (state_reg == S_LSBFIRST) && sclkFall && csLow;
   assign zeroEvt = (state_reg == S_ZEROS) && sclkFall && csLow;

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst || !csLow)
      begin
         state_reg <= S_IDLE;
         bitCount_reg <= 4'h0;
         sawRise_reg <= 1'b0;
      end
      else
      begin
         case (state_reg)
            S_IDLE:
               if (startEvt)
               begin
                  state_reg <= S_CONFIG;
                  bitCount_reg <= 4'h0;
               end
            S_CONFIG:
               if (sclkRise)
               begin
                  bitCount_reg <= bitCount_reg + 4'h1;
                  if (bitCount_reg == CONFIG_LAST)
                  begin
                     state_reg <= S_SAMPLE;
                     sawRise_reg <= 1'b0;
                  end
               end
            S_SAMPLE:
               // falling edge of the fifth clock after start
               if (sclkRise)
                  sawRise_reg <= 1'b1;
               else if (nullEvt)
               begin
                  state_reg <= S_CONVERT;
                  bitCount_reg <= MSB_INDEX;
               end
            S_CONVERT:
               if (convEvt)
               begin
                  if (bitCount_reg == 4'h0)
                  begin
                     state_reg <= S_LSBFIRST;
                     bitCount_reg <= 4'h1;
                  end
                  else
                     bitCount_reg <= bitCount_reg - 4'h1;
               end
            S_LSBFIRST:
               if (lsbEvt)
               begin
                  if (bitCount_reg == MSB_INDEX)
                     state_reg <= S_ZEROS;
                  else
                     bitCount_reg <= bitCount_reg + 4'h1;
               end
            S_ZEROS:
               state_reg <= S_ZEROS;
            default:
               state_reg <= S_IDLE;
         endcase
      end
   end

   // ****************************************************************
   // command capture and sampling window
   // ****************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst)
         chanConfig <= '0;
      else if ((state_reg == S_CONFIG) && sclkRise && csLow)
         chanConfig <= {chanConfig[CONFIG_BITS-2:0], pinsSync.din};
   end

   always_ff @(posedge mclk)
   begin
      if (rst || !csLow)
         sampleHold <= 1'b0;
      else if ((state_reg == S_CONFIG) && sclkRise && (bitCount_reg == CONFIG_LAST))
         sampleHold <= 1'b1;
      else if (nullEvt)
         sampleHold <= 1'b0;
   end

   // ****************************************************************
   // successive approximation
   // ****************************************************************
   function automatic logic [RESULT_BITS-1:0] sarStep(
      input logic [RESULT_BITS-1:0] trial,
      input logic [3:0] idx,
      input logic bitVal
   );
      logic [RESULT_BITS-1:0] r;
      r = trial;
      r[idx] = bitVal;
      if (idx != 4'h0)
         r[idx - 4'h1] = 1'b1;
      return r;
   endfunction

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         trialCode <= '0;
         resultBits_reg <= '0;
      end
      else if (nullEvt)
      begin
         trialCode <= TRIAL_FIRST;
         resultBits_reg <= '0;
      end
      else if (convEvt)
      begin
         // one comparison per serial clock, no free-running conversion
         trialCode <= sarStep(trialCode, bitCount_reg, compareAbove);
         resultBits_reg[bitCount_reg] <= compareAbove;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         result <= '0;
         resultValid <= 1'b0;
      end
      else
      begin
         resultValid <= convEvt && (bitCount_reg == 4'h0);
         if (convEvt && (bitCount_reg == 4'h0))
            result <= {resultBits_reg[RESULT_BITS-1:1], compareAbove};
      end
   end

   // ****************************************************************
   // serial output
   // ****************************************************************
   always_ff @(posedge mclk)
   begin
      if (rst || !csLow)
      begin
         doutOe <= 1'b0;
         dout <= 1'b0;
      end
      else if (nullEvt)
      begin
         // driver stays off until here: hi-z over start of byte two
         doutOe <= 1'b1;
         dout <= 1'b0;
      end
      else if (convEvt)
         dout <= compareAbove;
      else if (lsbEvt)
         dout <= resultBits_reg[bitCount_reg];
      else if (zeroEvt)
         dout <= 1'b0;
   end

   // ****************************************************************
   // hold time watch
   // ****************************************************************
   // flags a slow host; the result is still delivered, just suspect
   always_ff @(posedge mclk)
   begin
      if (rst)
      begin
         holdCount_reg <= '0;
         holdExpired <= 1'b0;
      end
      else if (startEvt)
      begin
         holdCount_reg <= '0;
         holdExpired <= 1'b0;
      end
      else if (state_reg == S_CONVERT && csLow)
      begin
         holdCount_reg <= holdCount_reg + 32'h1;
         if (holdCount_reg >= 32'(HOLD_LIMIT))
            holdExpired <= 1'b1;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence convStart;
      (state_reg == S_SAMPLE) && sawRise_reg && sclkFall && csLow;
   endsequence

   sequence lastConvBit;
      (state_reg == S_CONVERT) && sclkFall && csLow && (bitCount_reg == 4'h0);
   endsequence

   start_detect_a: assert property (startEvt |=> state_reg == S_CONFIG)
      else $error("start bit not taken");
   config_done_a: assert property ((state_reg == S_CONFIG) && sclkRise && csLow
      && (bitCount_reg == CONFIG_LAST) |=> (state_reg == S_SAMPLE) && sampleHold)
      else $error("sampling not begun after channel bits");
   null_bit_a: assert property (convStart |=> doutOe && !dout
      && (state_reg == S_CONVERT) && (bitCount_reg == MSB_INDEX))
      else $error("null bit not driven low");
   fall_only_a: assert property ($changed(dout) |-> $past(sclkFall) || $past(!csLow))
      else $error("serial output changed off a falling edge");
   hiz_before_a: assert property ($rose(doutOe) |-> $past(state_reg) == S_SAMPLE)
      else $error("output enabled before null bit");
   per_clock_a: assert property (convEvt && (bitCount_reg != 4'h0)
      |=> (bitCount_reg == $past(bitCount_reg) - 4'h1) && (dout == $past(compareAbove)))
      else $error("more or less than one bit per clock");
   lsb_repeat_a: assert property (lsbEvt |=> dout == resultBits_reg[$past(bitCount_reg)])
      else $error("lsb-first repeat wrong");
   trail_zero_a: assert property (zeroEvt |=> !dout)
      else $error("trailing bits not zero");
   result_done_a: assert property (lastConvBit |=> resultValid ##1 !resultValid)
      else $error("result pulse missing");
   release_hiz_a: assert property (!csLow |=> !doutOe && (state_reg == S_IDLE))
      else $error("output not released on deselect");

endmodule // adc_spi_readout

// File: tb/spi_host_model.sv
// Purpose: host serial controller model facing the converter readout
// Assumes: link pins change on mclk falling edges
// Notes: a released data line reads as the inverse of the last bit
`timescale 1ns/1ns
module spi_host_model
   import adc_spi_pkg::*;
(
   input wire logic mclk,
   input wire logic dout,
   input wire logic doutOe,
   output spi_in_t pins
);
   // ********
   // framed transfer
   // ********
   logic lastSeen;
   logic rxBit [0:63];
   logic rxOe [0:63];

   initial
   begin
      pins = 3'b100;
      lastSeen = 1'b0;
   end

   task automatic waitCyc(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic xfer(input int z, input int n, input logic [3:0] cfg, input logic idle,
      input int hMin, input int hMax);
      logic [63:0] tx;
      tx = 64'h0;
      tx[z] = 1'b1;
      for (int i = 0; i < 4; i++)
      begin
         tx[z + 1 + i] = cfg[3 - i];
      end
      pins.sclk = idle;
      waitCyc(2);
      pins.csN = 1'b0;
      waitCyc(hMax);
      for (int k = 0; k < n; k++)
      begin
         pins.sclk = 1'b0;
         pins.din = tx[k];
         // random halves: speed and duty vary within limits
         waitCyc(hMin + int'($urandom % (hMax - hMin + 1)));
         rxOe[k] = doutOe;
         rxBit[k] = doutOe ? dout : ~lastSeen;
         lastSeen = rxBit[k];
         pins.sclk = 1'b1;
         waitCyc(hMin + int'($urandom % (hMax - hMin + 1)));
      end
      pins.sclk = idle;
      waitCyc(hMax);
      pins.csN = 1'b1;
      pins.din = ~pins.din;
   endtask
endmodule // spi_host_model

// File: tb/testbench.sv
// Purpose: self-checking bench for the converter serial readout
// Assumes: comparator answers vin >= trialCode
// Notes: hold limit shortened to 200 mclk
`timescale 1ns/1ns
module testbench
   import adc_spi_pkg::*;
;
   // ********
   // signals
   // ********
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic compareAbove = 1'b0;
   logic [11:0] vin = 12'h000;
   spi_in_t pins;
   logic dout, doutOe, sampleHold, resultValid, holdExpired;
   chan_config_t chanConfig;
   logic [11:0] trialCode, result;
   logic prevDout = 1'b0;
   logic prevOe = 1'b0;
   logic prevSclk = 1'b0;
   int nFail = 0;
   int nChecks = 0;
   int nValid = 0;
   int cyc = 0;

   always #25 mclk = ~mclk;

   adc_spi_readout #(.HOLD_LIMIT(200)) DUT (.mclk(mclk), .rst(rst), .pinsIn(pins),
      .compareAbove(compareAbove), .dout(dout), .doutOe(doutOe), .chanConfig(chanConfig),
      .sampleHold(sampleHold), .trialCode(trialCode), .result(result),
      .resultValid(resultValid), .holdExpired(holdExpired));

   spi_host_model host (.mclk(mclk), .dout(dout), .doutOe(doutOe), .pins(pins));

   // ********
   // checking
   // ********
   task automatic printVerdict();
      if (nFail == 0 && nChecks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp)
      begin
         nFail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic expBit(input int j, input logic [11:0] v);
      if (j == 0 || j > 23)
         return 1'b0;
      if (j <= 12)
         return v[12 - j];
      return v[j - 12];
   endfunction

   always @(negedge mclk) compareAbove <= (vin >= trialCode);

   always @(posedge mclk)
   begin
      cyc++;
      if (resultValid === 1'b1)
         nValid++;
      if (doutOe === 1'b1 && prevOe === 1'b1 && dout !== prevDout)
         check(16'(prevSclk), 16'h0000);
      if (sampleHold === 1'b1)
         check(16'(doutOe), 16'h0000);
      prevDout <= dout;
      prevOe <= doutOe;
      prevSclk <= pins.sclk;
      // ceiling well above the planned traffic
      if (cyc == 20000)
      begin
         nFail++;
         printVerdict();
      end
   end

   task automatic run(input int z, input int n, input logic [3:0] cfg, input logic idle,
      input int hMin, input int hMax);
      int nv;
      int j;
      vin = 12'($urandom);
      nv = nValid;
      host.xfer(z, n, cfg, idle, hMin, hMax);
      for (int k = 0; k < n; k++)
      begin
         j = k + 1 - (z + 7);
         check(16'(host.rxOe[k]), 16'(j >= 0));
         if (j >= 0)
            check(16'(host.rxBit[k]), 16'(expBit(j, vin)));
      end
      host.waitCyc(6);
      check(16'(doutOe), 16'h0000);
      check(16'(sampleHold), 16'h0000);
      check(16'(chanConfig), 16'(cfg));
      check(16'(nValid - nv), 16'(n >= z + 19));
      if (n >= z + 19)
         check(16'(result), 16'(vin));
      if (n >= z + 19)
         check(16'(trialCode), 16'(vin));
      check(16'(holdExpired), 16'(hMin > 8));
   endtask

   initial
   begin
      void'($urandom(9));
      repeat (3) @(negedge mclk);
      rst = 1'b0;
      for (int i = 0; i < 16; i++)
      begin
         run((i == 6) ? 2 : 5, (i % 4 == 3) ? 40 : 24, 4'(i), i[0], 4, 6);
      end
      // abort mid-result, then a full one to show recovery
      run(5, 16, 4'h9, 1'b0, 4, 6);
      run(5, 24, 4'h6, 1'b1, 12, 12);
      run(5, 40, 4'ha, 1'b0, 4, 5);
      printVerdict();
   end
endmodule // testbench
